// ==== hw/gpb_defs.svh ====
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH
// Register offsets within one port's window (word index)
`define GPB_OFF_DIR        2'h0
`define GPB_OFF_LATCH      2'h1
`define GPB_OFF_LEVEL      2'h2
`define GPB_OFF_ODSEL      2'h3
// Port count and width
`define GPB_NUM_PORTS      7
`define GPB_PORT_WIDTH     16
// Address field layout: low two bits select register, next three the port
`define GPB_ADDR_REG_LSB   0
`define GPB_ADDR_PORT_LSB  2
// Debug pin control register (port index 7, register 0)
`define GPB_DBG_PORT       3'h7
`define GPB_DBG_REG        2'h0
`define GPB_DBG_TAE_BIT    0
// Reset values
`define GPB_DIR_RST        16'hFFFF
`define GPB_LATCH_RST      16'h0000
`define GPB_ODSEL_RST      16'h0000
`define GPB_TAE_RST        1'b1
// Shared pin positions on port A
`define GPB_TCK_BIT        1
`define GPB_TDI_BIT        4
`define GPB_TDO_BIT        5
`endif

// ==== hw/gpb_pkg.sv ====
`default_nettype none
package gpb_pkg;
  typedef logic [15:0] gpb_word_type;
  typedef enum logic [1:0] {GPB_REG_DIR, GPB_REG_LATCH, GPB_REG_LEVEL, GPB_REG_ODSEL}
    gpb_reg_sel_type;
endpackage
`default_nettype wire

// ==== hw/gpb_pin_sync.sv ====
`default_nettype none
// Two-stage synchroniser for a bus of pin levels
module gpb_pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_in,   // System clock
  input  wire logic             rst_b_in, // Async reset, active low
  input  wire logic [WIDTH-1:0] d_in,     // Raw pin levels
  output logic      [WIDTH-1:0] q_out     // Synchronised levels
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } gpb_sync_type;

  gpb_sync_type st_q;
  gpb_sync_type st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q_out = st_q.s2;
endmodule // gpb_pin_sync
`default_nettype wire

// ==== hw/gpb_port_bank.sv ====
// Notes on behaviour
// - Direction bit zero output, one input
// - Latch write drives all output pins
// - Latch read returns last written value
// - Level read returns synchronised pin levels
// - Level write acts as latch write
// - Open-drain bit one: drive low only
// - Seven 16-bit ports, absent bits masked
// - Four registers per port
// - Each pin independently controlled
// - Test-access owns shared pins until cleared
// - Serial pins ignore I/O while active
//
// The register addresses and strobed register access were decided locally.
`include "gpb_defs.svh"
`default_nettype none
module gpb_port_bank #(
  parameter int NUM_PORTS = `GPB_NUM_PORTS,
  parameter int WIDTH     = `GPB_PORT_WIDTH,
  parameter logic [`GPB_NUM_PORTS*`GPB_PORT_WIDTH-1:0] PIN_PRESENT = '1,
  parameter int SER_PORT  = 0,  // Port holding two-wire serial pins
  parameter int SER_CLK_BIT = 2,
  parameter int SER_DAT_BIT = 3
) (
  input  wire logic                        CLK_IN,        // 40 MHz clock
  input  wire logic                        RST_B_IN,      // Async reset, low
  input  wire logic [4:0]                  ADDR_IN,       // Word address
  input  wire logic [31:0]                 WDATA_IN,      // Write data
  input  wire logic                        WR_IN,         // Write strobe
  input  wire logic                        RD_IN,         // Read strobe
  output logic      [31:0]                 RDATA_OUT,     // Read data, next cycle
  input  wire logic [NUM_PORTS*WIDTH-1:0]  PIN_IN,        // Pin levels
  output logic      [NUM_PORTS*WIDTH-1:0]  PIN_OUT,       // Pin drive values
  output logic      [NUM_PORTS*WIDTH-1:0]  PIN_OE_OUT,    // Pin drive enables
  output logic                             TEST_EN_OUT,   // Test-access owns pins
  input  wire logic                        TEST_DO_IN,    // Test data out value
  input  wire logic                        TEST_DO_OE_IN, // Test data out enable
  input  wire logic                        SER_ACTIVE_IN, // Serial ctrl uses pins
  input  wire logic                        SER_CLK_OUT_IN,// Serial clock drive low
  input  wire logic                        SER_DAT_OUT_IN // Serial data drive low
);
  localparam int TOTAL = NUM_PORTS * WIDTH;

  typedef struct packed {
    logic [TOTAL-1:0] dir;
    logic [TOTAL-1:0] latch;
    logic [TOTAL-1:0] odsel;
    logic             tae;
    logic [31:0]      rdata;
    logic [TOTAL-1:0] pin;
    logic [TOTAL-1:0] oe;
  } gpb_state_type;

  gpb_state_type st_q;
  gpb_state_type st_d;
  logic [TOTAL-1:0] lvl_sync;

  // Pin levels come from outside the clock domain
  gpb_pin_sync #(.WIDTH(TOTAL)) u_sync (
    .clk_in   (CLK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     (PIN_IN),
    .q_out    (lvl_sync)
  );

  // Extract one port's word from a flattened vector
  function automatic gpb_pkg::gpb_word_type port_word(input logic [TOTAL-1:0] v,
                                                      input int p);
    port_word = v[p*WIDTH +: WIDTH] & PIN_PRESENT[p*WIDTH +: WIDTH];
  endfunction

  // Bit index of a shared pin within the flattened vector
  function automatic int bit_at(input int p, input int b);
    bit_at = p * WIDTH + b;
  endfunction

  // Register writes, read mux and pin driver muxing
  always_comb begin
    logic [2:0] port_sel;
    logic [1:0] reg_sel;
    logic       hit;
    int         p;
    logic [TOTAL-1:0] drv;
    port_sel = ADDR_IN[`GPB_ADDR_PORT_LSB +: 3];
    reg_sel  = ADDR_IN[`GPB_ADDR_REG_LSB +: 2];
    hit      = 32'(port_sel) < NUM_PORTS;
    p        = int'(port_sel);
    drv      = '0;
    st_d     = st_q;
    st_d.rdata = 32'h0000_0000;
    if (WR_IN && hit) begin
      case (reg_sel)
        `GPB_OFF_DIR:   st_d.dir[p*WIDTH +: WIDTH]   = WDATA_IN[WIDTH-1:0];
        `GPB_OFF_LATCH: st_d.latch[p*WIDTH +: WIDTH] = WDATA_IN[WIDTH-1:0];
        `GPB_OFF_LEVEL: st_d.latch[p*WIDTH +: WIDTH] = WDATA_IN[WIDTH-1:0];
        `GPB_OFF_ODSEL: st_d.odsel[p*WIDTH +: WIDTH] = WDATA_IN[WIDTH-1:0];
        default:        st_d.latch = st_q.latch;
      endcase
    end else if (WR_IN && port_sel == `GPB_DBG_PORT && reg_sel == `GPB_DBG_REG) begin
      st_d.tae = WDATA_IN[`GPB_DBG_TAE_BIT];
    end
    if (RD_IN && hit) begin
      case (reg_sel)
        `GPB_OFF_DIR:   st_d.rdata[WIDTH-1:0] = port_word(st_q.dir, p);
        `GPB_OFF_LATCH: st_d.rdata[WIDTH-1:0] = port_word(st_q.latch, p);
        `GPB_OFF_LEVEL: st_d.rdata[WIDTH-1:0] = port_word(lvl_sync, p);
        `GPB_OFF_ODSEL: st_d.rdata[WIDTH-1:0] = port_word(st_q.odsel, p);
        default:        st_d.rdata = 32'h0000_0000;
      endcase
    end else if (RD_IN && port_sel == `GPB_DBG_PORT && reg_sel == `GPB_DBG_REG) begin
      st_d.rdata[`GPB_DBG_TAE_BIT] = st_q.tae;
    end
    // Per-pin drivers; open drain drives only when low
    for (int i = 0; i < TOTAL; i++) begin
      drv[i] = !st_q.dir[i] && (!st_q.odsel[i] || !st_q.latch[i]);
    end
    st_d.pin = st_q.latch;
    st_d.oe  = drv & PIN_PRESENT[TOTAL-1:0];
    // Test-access pins: clock and data-in are inputs, data-out from controller
    if (st_q.tae) begin
      st_d.oe[bit_at(0, `GPB_TCK_BIT)]  = 1'b0;
      st_d.oe[bit_at(0, `GPB_TDI_BIT)]  = 1'b0;
      st_d.oe[bit_at(0, `GPB_TDO_BIT)]  = TEST_DO_OE_IN;
      st_d.pin[bit_at(0, `GPB_TDO_BIT)] = TEST_DO_IN;
    end
    // Serial controller pins are open drain, pulled low on its request
    if (SER_ACTIVE_IN) begin
      st_d.oe[bit_at(SER_PORT, SER_CLK_BIT)]  = SER_CLK_OUT_IN;
      st_d.pin[bit_at(SER_PORT, SER_CLK_BIT)] = 1'b0;
      st_d.oe[bit_at(SER_PORT, SER_DAT_BIT)]  = SER_DAT_OUT_IN;
      st_d.pin[bit_at(SER_PORT, SER_DAT_BIT)] = 1'b0;
    end
  end

  // Reset leaves every pin an input, test access owning its pins
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_q.dir   <= {NUM_PORTS{`GPB_DIR_RST}};
      st_q.latch <= {NUM_PORTS{`GPB_LATCH_RST}};
      st_q.odsel <= {NUM_PORTS{`GPB_ODSEL_RST}};
      st_q.tae   <= `GPB_TAE_RST;
      st_q.rdata <= 32'h0000_0000;
      st_q.pin   <= '0;
      st_q.oe    <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign RDATA_OUT   = st_q.rdata;
  assign PIN_OUT     = st_q.pin;
  assign PIN_OE_OUT  = st_q.oe;
  assign TEST_EN_OUT = st_q.tae;
endmodule // gpb_port_bank
`default_nettype wire

// ==== verification/gpb_pins.sv ====
`default_nettype none
// Connector lines as seen from outside the device
module gpb_pins (
  input  wire logic [111:0] out_in, // Drive value
  input  wire logic [111:0] oe_in,  // Drive enable
  output logic      [111:0] lvl_out // Pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up on every line, so a released pin never keeps its last value
  assign lvl_out = (out_in & oe_in) | ~oe_in;
endmodule // gpb_pins
`default_nettype wire

// ==== verification/gpb_port_bank_asserts.sv ====
`default_nettype none
module gpb_port_bank_asserts (
  input wire logic         CLK_IN,         // Clock
  input wire logic         RST_B_IN,       // Reset, active low
  input wire logic [4:0]   ADDR_IN,        // Address
  input wire logic [31:0]  WDATA_IN,       // Data
  input wire logic         WR_IN,          // Write
  input wire logic         RD_IN,          // Read
  input wire logic [31:0]  RDATA_OUT,      // Read data
  input wire logic [111:0] PIN_OUT,        // Drive
  input wire logic [111:0] PIN_OE_OUT,     // Enable
  input wire logic         TEST_EN_OUT,    // Test owns
  input wire logic         TEST_DO_IN,     // Test data out
  input wire logic         TEST_DO_OE_IN,  // Test data out enable
  input wire logic         SER_ACTIVE_IN,  // Serial owns pins
  input wire logic         SER_CLK_OUT_IN, // Serial clock pull low
  input wire logic         SER_DAT_OUT_IN  // Serial data pull low
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, reset gates all
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  property p_idle; !$past(RD_IN) |-> RDATA_OUT == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_lrb; WR_IN && ADDR_IN == 5'h05 ##1 RD_IN && ADDR_IN == 5'h05
    |=> RDATA_OUT[15:0] == $past(WDATA_IN[15:0], 2); endproperty
  a_lrb: assert property (p_lrb) else $error("latch readback");
  property p_lvw; WR_IN && ADDR_IN == 5'h06 ##1 RD_IN && ADDR_IN == 5'h05
    |=> RDATA_OUT[15:0] == $past(WDATA_IN[15:0], 2); endproperty
  a_lvw: assert property (p_lvw) else $error("level write");
  // Register first, pin drivers one edge later: two edges from strobe to pin
  property p_dir; WR_IN && ADDR_IN == 5'h04
    |-> ##2 PIN_OE_OUT[31:16] == ~$past(WDATA_IN[15:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction");
  property p_drv; WR_IN && ADDR_IN == 5'h05
    |-> ##2 ((PIN_OUT[31:16] ^ $past(WDATA_IN[15:0], 2)) & PIN_OE_OUT[31:16]) == 16'h0000;
  endproperty
  a_drv: assert property (p_drv) else $error("drive value");
  property p_tae; WR_IN && ADDR_IN == 5'h1C |=> TEST_EN_OUT == $past(WDATA_IN[0]); endproperty
  a_tae: assert property (p_tae) else $error("test enable");
  property p_own; TEST_EN_OUT && $past(TEST_EN_OUT) |-> !PIN_OE_OUT[1] && !PIN_OE_OUT[4];
  endproperty
  a_own: assert property (p_own) else $error("shared pin driven");
  // First edge after reset still shows reset drivers, so it is skipped
  property p_tdo; $past(RST_B_IN) && TEST_EN_OUT && $past(TEST_EN_OUT)
    |-> PIN_OE_OUT[5] == $past(TEST_DO_OE_IN) && PIN_OUT[5] == $past(TEST_DO_IN);
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data out pin");
  property p_ser; $past(RST_B_IN) && $past(SER_ACTIVE_IN)
    |-> PIN_OUT[3:2] == 2'b00
        && PIN_OE_OUT[3:2] == {$past(SER_DAT_OUT_IN), $past(SER_CLK_OUT_IN)};
  endproperty
  a_ser: assert property (p_ser) else $error("serial pin control");
  property p_rst; $rose(RST_B_IN) |-> PIN_OE_OUT == '0 && TEST_EN_OUT; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_wr: cover property (WR_IN && ADDR_IN == 5'h05);
  c_rd: cover property (RD_IN && ADDR_IN == 5'h0A);
  c_tae: cover property ($fell(TEST_EN_OUT));
  c_ser: cover property (SER_ACTIVE_IN && SER_CLK_OUT_IN);
endmodule // gpb_port_bank_asserts
bind gpb_port_bank gpb_port_bank_asserts u_gpb_port_bank_asserts (.*);
`default_nettype wire

// ==== verification/tb_gpb_port_bank.sv ====
`default_nettype none
module tb_gpb_port_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 0, rst_b = 0, wr = 0, rd = 0, test_en;
  logic         ser_act = 0, ser_clk = 0, ser_dat = 0, tdo = 0, tdo_oe = 0;
  logic [4:0]   addr = '0;
  logic [31:0]  wdata = '0, rdata;
  logic [111:0] pin_in, pin_out, pin_oe;
  int           num_errors = 0, checks = 0;
  gpb_port_bank u_gpb_port_bank (.CLK_IN(clk), .RST_B_IN(rst_b), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .TEST_EN_OUT(test_en), .TEST_DO_IN(tdo),
    .TEST_DO_OE_IN(tdo_oe), .SER_ACTIVE_IN(ser_act), .SER_CLK_OUT_IN(ser_clk),
    .SER_DAT_OUT_IN(ser_dat));
  gpb_pins u_gpb_pins (.out_in(pin_out), .oe_in(pin_oe), .lvl_out(pin_in));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // One strobe cycle; the next call may follow with no gap
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {16'h0000, d};
  endtask
  task automatic idle();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Read data only stands in the cycle after the strobe
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    idle();
    #1 chk(rdata, {16'h0000, e});
  endtask
  task automatic t_reset();
    chk({31'h0, |pin_oe}, 32'h0);
    rdc(5'h04, 16'hFFFF);
    rdc(5'h01, 16'h0000);
    rdc(5'h07, 16'h0000);
    rdc(5'h0B, 16'h0000);
    rdc(5'h1C, 16'h0001);
    rdc(5'h1D, 16'h0000);
  endtask
  // Port B: low byte out, high byte in under pull-up
  task automatic t_latch();
    bus(1'b1, 5'h04, 16'hFF00);
    bus(1'b1, 5'h05, 16'hA5C3);
    rdc(5'h05, 16'hA5C3);
    chk({16'h0, pin_oe[31:16]}, 32'h00FF);
    chk({24'h0, pin_out[23:16]}, 32'h00C3);
    idle();
    rdc(5'h06, 16'hFFC3);
    bus(1'b1, 5'h06, 16'h1234);
    rdc(5'h05, 16'h1234);
  endtask
  // Port C open-drain: ones released, zeros pulled low
  task automatic t_odrain();
    bus(1'b1, 5'h08, 16'h0000);
    bus(1'b1, 5'h0B, 16'hFFFF);
    bus(1'b1, 5'h09, 16'h00F0);
    idle();
    idle();
    #1 chk({16'h0, pin_oe[47:32]}, 32'hFF0F);
    chk({16'h0, pin_out[47:32]}, 32'h00F0);
    // Pin levels need one more cycle to clear the synchroniser
    idle();
    rdc(5'h0A, 16'h00F0);
  endtask
  // Port A shared pins: test access, then serial controller
  task automatic t_shared();
    bus(1'b1, 5'h00, 16'h0000);
    bus(1'b1, 5'h01, 16'hFFFF);
    @(posedge clk);
    wr     <= 1'b0;
    tdo_oe <= 1'b1;
    #1 chk({27'h0, pin_oe[5:1]}, 32'h06);
    idle();
    #1 chk({27'h0, pin_oe[5:1]}, 32'h16);
    chk({27'h0, pin_out[5:1]}, 32'h0F);
    // Enable clear lands first, pin drivers follow one edge later
    bus(1'b1, 5'h1C, 16'h0000);
    idle();
    idle();
    #1 chk({26'h0, test_en, pin_oe[5:1]}, 32'h1F);
    chk({27'h0, pin_out[5:1]}, 32'h1F);
    @(posedge clk);
    ser_act <= 1'b1;
    ser_clk <= 1'b1;
    idle();
    idle();
    #1 chk({27'h0, pin_oe[5:1]}, 32'h1B);
    chk({27'h0, pin_out[5:1]}, 32'h19);
  endtask
  // Reset in mid-run must undo earlier writes; t_reset rechecks four of the written registers
  task automatic t_rerun();
    @(posedge clk);
    ser_act <= 1'b0;
    ser_clk <= 1'b0;
    tdo_oe  <= 1'b0;
    rst_b   <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_latch();
    t_odrain();
    t_shared();
    t_rerun();
    conclude();
  end
  // Watchdog, far beyond the roughly 60 cycles needed
  initial begin
    #20us;
    num_errors++;
    conclude();
  end
endmodule // tb_gpb_port_bank
`default_nettype wire
